// File: verilog/rsmc_pkg.sv
// Behaviour
// - dsr follows dtr in the same cycle, with no added delay.
// - dcd is high only while the receive path reports a valid line signal.
// - the terminal raises rts before sending; cts follows after 8 ms or at once, per setting.
// - the line carrier is either always on or on only while rts is held.
// - no-echo works in both line forms; echo returns line data in four-wire form, and in two-wire form only while the carrier is off.
// - each data lamp is green while its data is positive, red while negative or idle.
// - the carrier lamp is green while carrier is detected, red while it is absent.
package rsmc_pkg;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned RTS_DELAY_MS  = 8;
	localparam int unsigned RTS_DELAY_CYC = (CLK_HZ / 1000) * RTS_DELAY_MS;
	localparam int unsigned DLY_W         = 19;
	localparam logic [DLY_W-1:0] DLY_RST  = 19'h00000;
	// lamp colour codes: bit 1 green, bit 0 red
	localparam logic [1:0] LAMP_GREEN = 2'h2;
	localparam logic [1:0] LAMP_RED   = 2'h1;
	typedef enum logic [1:0] {RSMC_IDLE, RSMC_WAIT, RSMC_CLEAR} rsmc_cts_e;
endpackage

// File: verilog/rsmc_lamp.sv
`timescale 1ns/1ps
// bicolour lamp driver, registered
module rsmc_lamp
	import rsmc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       level,
	output logic      [1:0] lamp
);
	import rsmc_pkg::*;

	logic [1:0] next_lamp;

	// positive level lights green, anything else red
	always_comb
	begin
		next_lamp = level ? LAMP_GREEN : LAMP_RED;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			lamp <= LAMP_RED;
		else
			lamp <= next_lamp;
	end
endmodule

// File: verilog/rsmc_core.sv
`timescale 1ns/1ps
// modem control handshake and status lamps of one port
module rsmc_core
	import rsmc_pkg::*;
#(
	parameter int unsigned DELAY_CYC = rsmc_pkg::RTS_DELAY_CYC
)
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       dtr,
	input  wire logic       rts,
	input  wire logic       term_txd,
	input  wire logic       line_rxd,
	input  wire logic       line_sig_valid,
	input  wire logic       cfg_cts_delay,
	input  wire logic       cfg_carrier_rts,
	input  wire logic       cfg_echo,
	input  wire logic       cfg_four_wire,
	output logic            dsr,
	output logic            dcd,
	output logic            cts,
	output logic            line_txd,
	output logic            line_tx_en,
	output logic            term_rxd,
	output logic      [1:0] transmit_activity_lamp,
	output logic      [1:0] receive_activity_lamp,
	output logic      [1:0] carrier_detect_lamp
);
	import rsmc_pkg::*;

	rsmc_cts_e        state;
	rsmc_cts_e        next_state;
	logic [DLY_W-1:0] count;
	logic [DLY_W-1:0] next_count;
	logic             next_line_txd;
	logic             next_term_rxd;
	logic             line_rx_data;

	// dsr is a pure wire so it cannot lag dtr
	assign dsr = dtr;
	assign dcd = line_sig_valid;
	// carrier: always on, or gated by rts
	assign line_tx_en = cfg_carrier_rts ? rts : 1'b1;
	// cts comes straight from the state register, so it cannot glitch
	assign cts = (state == RSMC_CLEAR);

	// in two-wire form the line carries our own transmit when driving,
	// so received data is only trusted while we are not transmitting;
	// limitation: two-wire form with carrier always on receives nothing
	assign line_rx_data = (cfg_four_wire || !line_tx_en) ? line_rxd : 1'b0;

	// rts to cts sequencer
	always_comb
	begin
		next_state = state;
		next_count = count;
		case (state)
			RSMC_IDLE:
			begin
				next_count = DLY_RST;
				if (rts)
					next_state = cfg_cts_delay ? RSMC_WAIT : RSMC_CLEAR;
			end
			RSMC_WAIT:
			begin
				// count is zero on the first waiting cycle, so the end point
				// DELAY_CYC-1 puts cts up exactly DELAY_CYC edges after the edge that first sees rts
				if (!rts)
					next_state = RSMC_IDLE;
				else if (count >= DLY_W'(DELAY_CYC - 1))
					next_state = RSMC_CLEAR;
				else
					next_count = count + 1'b1;
			end
			RSMC_CLEAR:
			begin
				if (!rts)
					next_state = RSMC_IDLE;
			end
			default:
				next_state = RSMC_IDLE;
		endcase
	end

	// state register; reset leaves cts low
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= RSMC_IDLE;
			count <= DLY_RST;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
		end
	end

	// data paths; echo returns line data to the line
	// echo replaces terminal data on the line, so the terminal cannot send
	// while echo is set: traded for a transmitter with a single source
	always_comb
	begin
		next_term_rxd = line_rx_data | !dcd; // idle mark when no carrier
		next_line_txd = cfg_echo ? line_rx_data : term_txd;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			line_txd <= 1'b1;
			term_rxd <= 1'b1;
		end
		else
		begin
			line_txd <= next_line_txd;
			term_rxd <= next_term_rxd;
		end
	end

	// data lamps: green on positive (space, logic 0) data, red on negative or idle; carrier lamp green while line_sig_valid is high
	// each lamp is registered so a glitch on its source never flickers it
	rsmc_lamp u_tx_lamp
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.level   (!term_txd),
		.lamp    (transmit_activity_lamp)
	);

	rsmc_lamp u_rx_lamp
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.level   (!term_rxd),
		.lamp    (receive_activity_lamp)
	);

	rsmc_lamp u_cd_lamp
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.level   (line_sig_valid),
		.lamp    (carrier_detect_lamp)
	);

	// assertions guard the control handshake, the data paths and the lamps
	// cts never comes early in delayed mode
	sequence s_rts_rise;
		$rose(rts) && cfg_cts_delay && state == RSMC_IDLE;
	endsequence

	AST_DSR_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		dsr == dtr) else $error("dsr differs from dtr");
	AST_DCD_VALID: assert property (@(posedge ref_clk) disable iff (!rst_b)
		dcd == line_sig_valid) else $error("dcd not tied to line signal");
	AST_CTS_IMMEDIATE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state == RSMC_IDLE && rts && !cfg_cts_delay) |=> cts) else $error("cts late in zero mode");
	AST_CTS_NOT_EARLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_rts_rise |=> !cts) else $error("cts early in delay mode");
	AST_CTS_NEEDS_RTS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(cts) |-> $past(rts)) else $error("cts without rts");
	AST_CARRIER: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cfg_carrier_rts ? line_tx_en == rts : line_tx_en)) else $error("carrier wrong");
	AST_ECHO: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cfg_echo && cfg_four_wire) |=> line_txd == $past(line_rxd)) else $error("echo lost");
	AST_NO_ECHO: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!cfg_echo |=> line_txd == $past(term_txd)) else $error("no-echo path wrong");
	AST_TX_LAMP: assert property (@(posedge ref_clk) disable iff (!rst_b)
		term_txd |=> transmit_activity_lamp == LAMP_RED) else $error("tx lamp not red");
	AST_CD_LAMP: assert property (@(posedge ref_clk) disable iff (!rst_b)
		line_sig_valid |=> carrier_detect_lamp == LAMP_GREEN) else $error("cd lamp not green");

	// each lamp is checked in both colours
	AST_CD_LAMP_RED: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!line_sig_valid |=> carrier_detect_lamp == LAMP_RED) else $error("cd lamp not red");
	AST_TX_LAMP_GREEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!term_txd |=> transmit_activity_lamp == LAMP_GREEN) else $error("tx lamp not green");

	// receive lamp trails term_rxd by one register
	AST_RX_LAMP_RED: assert property (@(posedge ref_clk) disable iff (!rst_b)
		term_rxd |=> receive_activity_lamp == LAMP_RED) else $error("rx lamp not red");
	AST_RX_LAMP_GREEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!term_rxd |=> receive_activity_lamp == LAMP_GREEN) else $error("rx lamp not green");

	// the terminal sees a steady mark while no line signal is recognised
	AST_RX_MARK: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!dcd |=> term_rxd) else $error("receive data not at mark without carrier");
	// four-wire receive data reaches the terminal one register later
	AST_RX_PASS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(dcd && cfg_four_wire) |=> term_rxd == $past(line_rxd)) else $error("receive path wrong");
	// two-wire echo still works while our own transmitter is off the pair
	AST_ECHO_TWO_WIRE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cfg_echo && !cfg_four_wire && !line_tx_en) |=> line_txd == $past(line_rxd))
		else $error("two-wire echo lost");

	// delay window: rts still held while the counter runs
	sequence s_wait_run;
		state == RSMC_WAIT && rts;
	endsequence

	// last waiting cycle: the counter has reached its end point
	sequence s_wait_done;
		s_wait_run ##0 count == DLY_W'(DELAY_CYC - 1);
	endsequence

	// rts dropped while cts is up
	sequence s_rts_drop;
		cts && !rts;
	endsequence

	// exact delay: cts comes on the cycle after the end point, never before
	AST_CTS_AT_END: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_wait_done |=> cts) else $error("cts not raised at end of delay");
	AST_CTS_IN_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(s_wait_run ##0 count < DLY_W'(DELAY_CYC - 1)) |=> !cts) else $error("cts before delay end");
	// cts falls one cycle after rts is seen low
	AST_CTS_DROPS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_rts_drop |=> !cts) else $error("cts held after rts dropped");
	// a delay always starts from zero, so a dropped rts restarts it
	AST_DELAY_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state == RSMC_IDLE) |=> (state != RSMC_WAIT || count == DLY_RST))
		else $error("delay did not restart from zero");
endmodule

// File: bench/rsmc_term_model.sv
`timescale 1ns/1ps
// terminal: sends data only once cts is back, else idles at mark
module rsmc_term_model
(
	input  wire logic ref_clk,
	input  wire logic want_dtr,
	input  wire logic want_rts,
	input  wire logic cts,
	output logic      dtr,
	output logic      rts,
	output logic      term_txd
);
	initial {dtr, rts, term_txd} = 3'h1;
	// falling edge, clear of the sampling edge
	always @(negedge ref_clk)
	begin
		dtr <= want_dtr;
		rts <= want_rts;
		term_txd <= (rts && cts) ? 1'($urandom) : 1'h1;
	end
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module testbench;
	import rsmc_pkg::*;
	localparam int D = 8;
	logic ref_clk = 0, rst_b = 0, want_dtr = 0, want_rts = 0;
	logic line_rxd = 1, line_sig_valid = 0, e_txd = 1, e_rxd = 1, e_gate = 1;
	logic cfg_cts_delay = 0, cfg_carrier_rts = 0, cfg_echo = 0, cfg_four_wire = 0;
	logic dtr, rts, term_txd, dsr, dcd, cts, line_txd, line_tx_en, term_rxd;
	logic [1:0] tx_l, rx_l, cd_l, e_rl = LAMP_RED, e_tl = LAMP_RED, e_cl = LAMP_RED;
	int errors = 0, tests_run = 0, cyc = 0, cnt = 0;
	always #10 ref_clk = ~ref_clk;
	rsmc_term_model u_rsmc_term_model (.ref_clk, .want_dtr, .want_rts, .cts, .dtr, .rts,
		.term_txd);
	rsmc_core #(.DELAY_CYC(D)) u_rsmc_core (.ref_clk, .rst_b, .dtr, .rts, .term_txd,
		.line_rxd, .line_sig_valid, .cfg_cts_delay, .cfg_carrier_rts, .cfg_echo,
		.cfg_four_wire, .dsr, .dcd, .cts, .line_txd, .line_tx_en, .term_rxd,
		.transmit_activity_lamp(tx_l), .receive_activity_lamp(rx_l), .carrier_detect_lamp(cd_l));
	function automatic logic [1:0] colour(input logic v);
		return v ? LAMP_RED : LAMP_GREEN;
	endfunction
	task automatic end_sim();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// reference model, fed by what each rising edge samples
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			errors++;
			end_sim();
		end
		else
		begin
			cnt = (rst_b && rts) ? ((cnt > D) ? cnt : cnt + 1) : 0;
			// rx lamp trails term_rxd by one edge, so it takes the older value
			e_rl = rst_b ? colour(e_rxd) : LAMP_RED;
			// two-wire: line data is ignored while our carrier is on
			e_gate = line_rxd && (cfg_four_wire || (cfg_carrier_rts && !rts));
			e_txd = !rst_b || (cfg_echo ? e_gate : term_txd);
			e_rxd = !rst_b || e_gate || !line_sig_valid;
			e_tl = rst_b ? colour(term_txd) : LAMP_RED;
			e_cl = rst_b ? colour(!line_sig_valid) : LAMP_RED;
		end
	end
	// check settled outputs, then move the line inputs
	task automatic step();
		@(negedge ref_clk);
		`CHK(cts, logic'(cnt >= (cfg_cts_delay ? D + 1 : 1)))
		`CHK(line_txd, e_txd)
		`CHK(term_rxd, e_rxd)
		`CHK(tx_l, e_tl)
		`CHK(cd_l, e_cl)
		`CHK(rx_l, e_rl)
		if ($urandom_range(3) == 0) line_rxd = ~line_rxd;
		if ($urandom_range(15) == 0) line_sig_valid = ~line_sig_valid;
		#1;
		`CHK(dsr, dtr)
		`CHK(dcd, line_sig_valid)
		`CHK(line_tx_en, cfg_carrier_rts ? rts : 1'h1)
	endtask
	// every setting combination, each with rts idle and raised
	initial
	begin
		void'($urandom(32'h0d1d9cb6));
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) rst_b = 1;
		for (int i = 0; i < 32; i++)
		begin
			want_rts <= 0;
			repeat (3) step();
			{cfg_cts_delay, cfg_carrier_rts, cfg_echo, cfg_four_wire} = 4'(i >> 1);
			want_rts <= i[0];
			want_dtr <= 1'($urandom);
			repeat (20) step();
		end
		end_sim();
	end
endmodule
